// ==== nsx_map.svh ====
// Encodings, field positions and reset values of the swap/xor/direction unit.
`ifndef NSX_MAP_SVH
`define NSX_MAP_SVH

// Instruction word layout.
`define NSX_IW_WIDTH 14
`define NSX_OPC_HI 13
`define NSX_OPC_LO 8
`define NSX_DEST_BIT 7
`define NSX_FADDR_HI 6
`define NSX_LIT_HI 7
`define NSX_DIROPC_LO 3
`define NSX_DIRSEL_HI 2

// Opcode values.
`define NSX_OPC_SWAP 6'h0E
`define NSX_OPC_XORL 6'h3A
`define NSX_OPC_DIRLD 11'h00C

// Direction register selection by the direction load instruction.
`define NSX_DIR_FIRST 3'h5
`define NSX_DIR_LAST 3'h7
`define NSX_DIR_COUNT 3

// Direct file address of the first direction register, and reset value.
`define NSX_DIR_BASE 8'h85
`define NSX_DIR_RESET 8'hFF

// Accumulator and zero flag reset values, and the zero byte.
`define NSX_ACC_RESET 8'h00
`define NSX_ZERO_RESET 1'b0
`define NSX_BYTE_ZERO 8'h00

`endif

// ==== nsx_pkg.sv ====
// Types shared by the swap/xor/direction unit.
`default_nettype none
package nsx_pkg;

  // Decoded operation of the current instruction word.
  typedef enum logic [1:0] {
    nsx_op_none  = 2'b00,
    nsx_op_swap  = 2'b01,
    nsx_op_xorl  = 2'b10,
    nsx_op_dirld = 2'b11
  } nsx_op_type;

endpackage
`default_nettype wire

// ==== nsx_dec_if.sv ====
// Interface carrying the instruction word to the decoder and its fields back.
`timescale 1ns/1ps
`default_nettype none
interface nsx_dec_if;
  import nsx_pkg::*;

  logic [13:0] instr_word;
  logic instr_valid;
  nsx_op_type op;
  logic dest_file;
  logic [6:0] file_addr;
  logic [7:0] literal;
  logic [1:0] dir_index;

  // The decoder sees the word and returns the fields.
  modport dec (
    input instr_word, instr_valid,
    output op, dest_file, file_addr, literal, dir_index
  );

  // The execute unit supplies the word and uses the fields.
  modport exec (
    output instr_word, instr_valid,
    input op, dest_file, file_addr, literal, dir_index
  );
endinterface
`default_nettype wire

// ==== nsx_decode.sv ====
// Combinational decoder for the swap, xor literal and direction load words.
`timescale 1ns/1ps
`default_nettype none
`include "nsx_map.svh"
module nsx_decode (
  nsx_dec_if.dec dif
);
  import nsx_pkg::*;

  logic [2:0] dir_sel;

  // Field extraction is the same for every operation.
  assign dif.dest_file = dif.instr_word[`NSX_DEST_BIT];
  assign dif.file_addr = dif.instr_word[`NSX_FADDR_HI:0];
  assign dif.literal = dif.instr_word[`NSX_LIT_HI:0];
  assign dir_sel = dif.instr_word[`NSX_DIRSEL_HI:0];

  // Direction index counts from the first direction register.
  assign dif.dir_index = 2'(dir_sel - `NSX_DIR_FIRST);

  // Opcode match; a direction load outside its select range is no operation.
  always_comb begin
    dif.op = nsx_op_none;
    if (dif.instr_valid) begin
      if (dif.instr_word[`NSX_OPC_HI:`NSX_OPC_LO] == `NSX_OPC_SWAP) begin
        dif.op = nsx_op_swap;
      end else if (dif.instr_word[`NSX_OPC_HI:`NSX_OPC_LO] == `NSX_OPC_XORL)
      begin
        dif.op = nsx_op_xorl;
      end else if (dif.instr_word[`NSX_OPC_HI:`NSX_DIROPC_LO] ==
                   `NSX_OPC_DIRLD && dir_sel >= `NSX_DIR_FIRST &&
                   dir_sel <= `NSX_DIR_LAST) begin
        dif.op = nsx_op_dirld;
      end
    end
  end
endmodule // nsx_decode
`default_nettype wire

// ==== nsx_exec.sv ====
// Execute unit for nibble swap, xor literal and direction load instructions.
`timescale 1ns/1ps
`default_nettype none
`include "nsx_map.svh"
// Behaviour
// - Nibble swap exchanges the byte's nibbles; flags unchanged.
// - Swap result goes to accumulator if dest is 0, else to file.
// - Xor literal stores accumulator xor literal; updates zero flag.
// - Direction load copies accumulator to register 5 to 7; flags kept.
// - Direction registers are also read and written by file address.
module nsx_exec (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic [7:0] file_rd_data,
  output logic [6:0] file_addr,
  output logic file_wr_en,
  output logic [7:0] file_wr_data,
  input wire logic [7:0] dir_acc_addr,
  input wire logic dir_acc_wr,
  input wire logic [7:0] dir_acc_wdata,
  output logic [7:0] dir_acc_rdata,
  output logic dir_acc_hit,
  output logic [7:0] acc_value,
  output logic zero_flag,
  output logic [23:0] dir_value,
  output nsx_pkg::nsx_op_type exec_op
);
  import nsx_pkg::*;

  nsx_dec_if dif ();

  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  logic zero_reg;
  logic zero_next;
  logic [7:0] swapped;
  logic [7:0] xor_result;
  logic [7:0] dir_reg [0:2];
  logic [1:0] direct_idx;
  logic direct_hit;

  // The instruction word feeds the decoder through the carrier.
  assign dif.instr_word = instr_word;
  assign dif.instr_valid = instr_valid;

  nsx_decode u_decode (
    .dif(dif)
  );

  assign exec_op = dif.op;

  // Swap the two nibbles of the addressed byte.
  assign swapped = {file_rd_data[3:0], file_rd_data[7:4]};

  // Exclusive OR of accumulator and literal.
  assign xor_result = acc_reg ^ dif.literal;

  // The datapath sees the address at once and writes back in the same cycle.
  assign file_addr = dif.file_addr;
  assign file_wr_en = (dif.op == nsx_op_swap) && dif.dest_file;
  assign file_wr_data = swapped;

  // Next accumulator value for each operation.
  always_comb begin
    acc_next = acc_reg;
    unique case (dif.op)
      nsx_op_swap: begin
        if (!dif.dest_file) begin
          acc_next = swapped;
        end
      end
      nsx_op_xorl: begin
        acc_next = xor_result;
      end
      nsx_op_dirld: begin
        acc_next = acc_reg;
      end
      nsx_op_none: begin
        acc_next = acc_reg;
      end
    endcase
  end

  // Only the xor literal touches the zero flag; others hold it.
  always_comb begin
    zero_next = zero_reg;
    if (dif.op == nsx_op_xorl) begin
      zero_next = (xor_result == `NSX_BYTE_ZERO);
    end
  end

  // Accumulator register, updated in the instruction's own cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_reg <= `NSX_ACC_RESET;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // Zero flag register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      zero_reg <= `NSX_ZERO_RESET;
    end else begin
      zero_reg <= zero_next;
    end
  end

  assign acc_value = acc_reg;
  assign zero_flag = zero_reg;

  // Direct file access decode for the direction registers.
  always_comb begin
    direct_hit = 1'b0;
    direct_idx = 2'h0;
    for (int i = 0; i < `NSX_DIR_COUNT; i++) begin
      if (dir_acc_addr == 8'(`NSX_DIR_BASE + i)) begin
        direct_hit = 1'b1;
        direct_idx = 2'(i);
      end
    end
  end

  assign dir_acc_hit = direct_hit;
  assign dir_acc_rdata = direct_hit ? dir_reg[direct_idx] : `NSX_BYTE_ZERO;

  // One direction register per port; the instruction wins over a direct write.
  for (genvar g = 0; g < `NSX_DIR_COUNT; g++) begin : g_dir
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        dir_reg[g] <= `NSX_DIR_RESET;
      end else if (dif.op == nsx_op_dirld && dif.dir_index == 2'(g)) begin
        dir_reg[g] <= acc_reg;
      end else if (dir_acc_wr && direct_hit && direct_idx == 2'(g)) begin
        dir_reg[g] <= dir_acc_wdata;
      end
    end
    assign dir_value[g*8 +: 8] = dir_reg[g];
  end

  // Checks on the three instructions and the direct access path.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Swap into the accumulator gives the exchanged nibbles of the source.
  a_swap_to_acc: assert property (
    dif.op == nsx_op_swap && !dif.dest_file |=>
      acc_reg == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])})
    else $error("swap to accumulator gave a wrong value");

  // A swap never changes the zero flag.
  a_swap_flag_hold: assert property (
    dif.op == nsx_op_swap |=> zero_reg == $past(zero_reg))
    else $error("swap changed the zero flag");

  // Swap to the file writes back in its own cycle and leaves the accumulator.
  a_swap_to_file: assert property (
    dif.op == nsx_op_swap && dif.dest_file |->
      file_wr_en && file_wr_data == {file_rd_data[3:0], file_rd_data[7:4]}
      && file_addr == instr_word[6:0] ##1 acc_reg == $past(acc_reg))
    else $error("swap to file wrote the wrong data or moved the accumulator");

  // Xor literal result lands in the accumulator one edge later.
  a_xor_result: assert property (
    dif.op == nsx_op_xorl |=>
      acc_reg == ($past(acc_reg) ^ $past(instr_word[7:0])))
    else $error("xor literal gave a wrong accumulator");

  // Zero flag follows the xor result.
  a_xor_zero: assert property (
    dif.op == nsx_op_xorl |=> zero_reg == (acc_reg == `NSX_BYTE_ZERO))
    else $error("xor literal set the zero flag wrongly");

  // Direction load copies the accumulator and keeps the flags.
  a_dirld_copy: assert property (
    dif.op == nsx_op_dirld |=>
      dir_reg[$past(dif.dir_index)] == $past(acc_reg) &&
      zero_reg == $past(zero_reg) && acc_reg == $past(acc_reg))
    else $error("direction load did not copy the accumulator");

  // A direct write with no direction load in that cycle lands in its direction register next.
  a_direct_write: assert property (
    dir_acc_wr && direct_hit && dif.op != nsx_op_dirld |=>
      dir_reg[$past(direct_idx)] == $past(dir_acc_wdata))
    else $error("direct write to a direction register was lost");

  // The file write strobe appears only for a swap to the file.
  a_file_wr_only: assert property (
    file_wr_en |-> instr_valid && instr_word[`NSX_DEST_BIT] &&
      instr_word[`NSX_OPC_HI:`NSX_OPC_LO] == `NSX_OPC_SWAP)
    else $error("file write without a swap to the file");

  // A direction load naming a register below 5 does nothing.
  a_dirld_refuse: assert property (
    instr_word[`NSX_OPC_HI:`NSX_DIROPC_LO] == `NSX_OPC_DIRLD &&
      instr_word[`NSX_DIRSEL_HI:0] < `NSX_DIR_FIRST |->
      dif.op == nsx_op_none)
    else $error("direction load outside its range was executed");

  // Direction registers change only by a load or a direct write.
  a_dir_hold: assert property (
    dif.op != nsx_op_dirld && !(dir_acc_wr && direct_hit) |=>
      dir_value == $past(dir_value))
    else $error("a direction register changed with no load or write");

  // A direct hit means the address names one of the direction registers.
  a_hit_range: assert property (
    dir_acc_hit == (dir_acc_addr >= `NSX_DIR_BASE &&
      dir_acc_addr < `NSX_DIR_BASE + `NSX_DIR_COUNT))
    else $error("direct access hit decode is wrong");

  // A direct read that misses the direction registers returns zero.
  a_miss_zero: assert property (
    !dir_acc_hit |-> dir_acc_rdata == `NSX_BYTE_ZERO)
    else $error("direct read outside the direction registers was not zero");

  // With no instruction the accumulator and flag stay put.
  a_idle_hold: assert property (
    !instr_valid |=> acc_reg == $past(acc_reg) && zero_reg == $past(zero_reg))
    else $error("state changed without an instruction");

  c_swap_acc: cover property (dif.op == nsx_op_swap && !dif.dest_file);
  c_swap_file: cover property (dif.op == nsx_op_swap && dif.dest_file);
  c_xor_zero: cover property (dif.op == nsx_op_xorl ##1 zero_reg);
  c_dirld: cover property (dif.op == nsx_op_dirld);
  c_direct_wr: cover property (dir_acc_wr && direct_hit);

endmodule // nsx_exec
`default_nettype wire

// ==== nsx_file_model.sv ====
// Behavioural file register datapath facing the execute unit.
`timescale 1ns/1ps
`default_nettype none
module nsx_file_model (
  input wire logic clk,
  input wire logic [6:0] file_addr,
  input wire logic file_wr_en,
  input wire logic [7:0] file_wr_data,
  output logic [7:0] file_rd_data
);
  logic [7:0] mem [128];

  // Each location starts from a fixed pattern that the bench can predict.
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 37 + 3);
    end
  end

  // Reads are combinational, so one-cycle execution sees data at once.
  assign file_rd_data = mem[file_addr];

  // A write-back lands on the edge that executes the instruction.
  always @(posedge clk) begin
    if (file_wr_en === 1'b1) begin
      mem[file_addr] <= file_wr_data;
    end
  end
endmodule // nsx_file_model
`default_nettype wire

// ==== nibble_swap_xor_dir_exec_tb.sv ====
// Self-checking testbench for the swap, xor literal and direction unit.
`timescale 1ns/1ps
`default_nettype none
module nibble_swap_xor_dir_exec_tb;
  import nsx_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0] dir_acc_addr = 8'h00;
  logic dir_acc_wr = 1'b0;
  logic [7:0] dir_acc_wdata = 8'h00;
  logic [7:0] file_rd_data, file_wr_data, dir_acc_rdata, acc_value, acc_exp;
  logic [6:0] file_addr;
  logic file_wr_en, dir_acc_hit, zero_flag, zero_exp;
  logic [23:0] dir_value, dir_exp;
  nsx_op_type exec_op;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  // The clock toggles every half period of 5 ns.
  always #5 clk = ~clk;

  nsx_exec i_dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .file_rd_data(file_rd_data),
    .file_addr(file_addr), .file_wr_en(file_wr_en),
    .file_wr_data(file_wr_data), .dir_acc_addr(dir_acc_addr),
    .dir_acc_wr(dir_acc_wr), .dir_acc_wdata(dir_acc_wdata),
    .dir_acc_rdata(dir_acc_rdata), .dir_acc_hit(dir_acc_hit),
    .acc_value(acc_value), .zero_flag(zero_flag), .dir_value(dir_value),
    .exec_op(exec_op));

  nsx_file_model i_mem (.clk(clk), .file_addr(file_addr),
    .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
    .file_rd_data(file_rd_data));

  // Compares a value of up to 24 bits and counts the outcome.
  task automatic chk_val(input logic [23:0] g, input logic [23:0] e,
                         input string what);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, g, e);
    end
  endtask

  // Predicts the model's starting byte and the nibble exchange.
  function automatic logic [7:0] seed(input int a);
    return 8'(a * 37 + 3);
  endfunction
  function automatic logic [7:0] swp(input logic [7:0] b);
    return {b[3:0], b[7:4]};
  endfunction

  // Presents one instruction word and checks its decode in that cycle.
  task automatic issue(input logic [13:0] w, input nsx_op_type op);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    #1;
    chk_val(exec_op, op, "decoded operation");
  endtask

  // Lets the last word execute, then checks every register.
  task automatic retire();
    @(posedge clk);
    instr_valid <= 1'b0;
    dir_acc_wr <= 1'b0;
    #1;
    chk_val(acc_value, acc_exp, "accumulator");
    chk_val(zero_flag, zero_exp, "zero flag");
    chk_val(dir_value, dir_exp, "direction registers");
  endtask

  // Back-to-back xor literals, the last one clearing the accumulator.
  task automatic t_xor();
    issue({6'h3A, 8'hB5}, nsx_op_xorl);
    issue({6'h3A, 8'hAF}, nsx_op_xorl);
    chk_val(acc_value, 8'hB5, "first xor");
    issue({6'h3A, 8'h1A}, nsx_op_xorl);
    chk_val(acc_value, 8'h1A, "second xor");
    acc_exp = 8'h00;
    zero_exp = 1'b1;
    retire();
    issue(14'h3B55, nsx_op_none); // Unknown word is ignored.
    retire();
  endtask

  // Swap to the accumulator, swap back to the file, then reread.
  task automatic t_swap();
    issue({6'h0E, 1'b0, 7'h7F}, nsx_op_swap);
    chk_val(file_addr, 7'h7F, "file address");
    chk_val(file_wr_en, 1'b0, "no write-back");
    acc_exp = swp(seed(127));
    retire();
    issue({6'h0E, 1'b1, 7'h25}, nsx_op_swap);
    chk_val(file_wr_en, 1'b1, "write-back");
    chk_val(file_wr_data, swp(seed(37)), "write data");
    retire();
    issue({6'h0E, 1'b0, 7'h25}, nsx_op_swap);
    acc_exp = seed(37);
    retire();
  endtask

  // Loads each direction register, then one out of range.
  task automatic t_dir();
    for (int f = 5; f < 8; f++) begin
      issue({6'h3A, 8'(f * 17)}, nsx_op_xorl);
      acc_exp = acc_exp ^ 8'(f * 17);
      zero_exp = (acc_exp == 8'h00);
      issue({11'h00C, 3'(f)}, nsx_op_dirld);
      dir_exp[(f - 5) * 8 +: 8] = acc_exp;
      retire();
    end
    issue({11'h00C, 3'h4}, nsx_op_none);
    retire();
  endtask

  // Direct writes, a miss, and a collision with a direction load.
  task automatic t_direct();
    @(posedge clk);
    dir_acc_addr <= 8'h86;
    dir_acc_wr <= 1'b1;
    dir_acc_wdata <= 8'h3C;
    #1;
    chk_val(dir_acc_hit, 1'b1, "hit");
    @(posedge clk);
    dir_acc_addr <= 8'h84;
    #1;
    dir_exp[15:8] = 8'h3C;
    chk_val(dir_value, dir_exp, "direct write");
    chk_val({dir_acc_hit, dir_acc_rdata}, 9'h000, "miss");
    @(posedge clk);
    dir_acc_addr <= 8'h87;
    instr_valid <= 1'b1;
    instr_word <= {11'h00C, 3'h7};
    dir_exp[23:16] = acc_exp;
    retire();
    chk_val(dir_acc_rdata, acc_exp, "read back");
    @(posedge clk);
    dir_acc_addr <= 8'h86;
    #1;
    chk_val(dir_acc_rdata, 8'h3C, "direct read");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the length of the sequence.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 500) begin
      errors++;
      $display("[FAIL] %0t run did not finish", $time);
      final_report();
    end
  end

  // Reset, reset values, then each scenario in turn.
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    acc_exp = 8'h00;
    zero_exp = 1'b0;
    dir_exp = 24'hFFFFFF;
    chk_val({acc_value, zero_flag}, 9'h000, "reset state");
    chk_val(dir_value, dir_exp, "reset direction");
    t_xor();
    t_swap();
    t_dir();
    t_direct();
    final_report();
  end
endmodule // nibble_swap_xor_dir_exec_tb
`default_nettype wire
